// file: hw/pgpm_pin_sel.sv
/*
 * Pin function selector for a pin shared by port, timer compare output and
 * dual-port RAM data bus.
 * Assumes all inputs are synchronous to the same clock; purely combinational.
 */
`timescale 1ns/1ns
module pgpm_pin_sel
(
	pgpm_pin_if.sel p
);
	import pgpm_pkg::*;

	// ---------------------------------------------------------------
	// Selection
	// ---------------------------------------------------------------
	// Don't-care columns collapse into the priority order below.
	always_comb
	begin
		if (p.slave_en)
		begin
			p.fn       = PGPM_FN_DPR;
			p.pin_out  = p.dpr_out;
			p.pin_oe_n = ~p.dpr_drive;
		end
		else if (p.cmp_oe)
		begin
			p.fn       = PGPM_FN_TMR;
			p.pin_out  = p.cmp_out;
			p.pin_oe_n = 1'b0;
		end
		else
		begin
			p.fn       = p.dir ? PGPM_FN_OUT : PGPM_FN_IN;
			p.pin_out  = p.port_out;
			p.pin_oe_n = ~p.dir;
		end
	end

endmodule : pgpm_pin_sel

// file: hw/pgpm_port.sv
/*
 * Port 4 general-purpose I/O with pin multiplexing for pins 7 and 6.
 * Assumes a classic Wishbone master, standby requests from the system
 * controller, and the timer and dual-port RAM logic outside this block.
 */
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
// Behaviour
// - Direction bit 1 makes a pin output, 0 makes it input.
// - Direction register is write-only; reads return all ones.
// - Reset and hardware standby clear the direction register.
// - Software standby keeps direction, so outputs keep driving.
// - Software standby resets peripheral ownership back to port control.
// - Port read returns data register for bits with direction 1.
// - Port read returns sampled pin level for bits with direction 0.
// - Read-back rule also applies to peripheral-owned pins.
// - Data register clears on reset and hardware standby, keeps through software standby.
// - Pins are shared among port, RAM bus, timers and compare outputs.
// - Slave-mode enable set to 1 hands pins to the RAM data bus.
// - Don't-care selection entries give the same function either way.
module pgpm_port
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  hw_standby_i,
	input  wire logic                  sw_standby_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [3:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic [7:0]            pin_i,
	output logic      [7:0]            pin_o,
	output logic      [7:0]            pin_oe_n_o,
	input  wire logic                  timer_compare_a_out_i,
	input  wire logic                  timer_compare_b_out_i,
	input  wire logic [7:6]            dual_port_ram_data_bus_i,
	input  wire logic                  dual_port_ram_drive_i,
	output logic      [7:6]            dual_port_ram_data_bus_o,
	output logic                       slave_mode_enable_o,
	output logic                       periph_reset_o,
	output pgpm_pkg::pgpm_fn_t [7:6]   pin_fn_o
);
	import pgpm_pkg::*;

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0]  port_direction;
	logic [7:0]  port_output_data;
	logic        slave_mode_enable;
	logic [1:0]  cmp_oe;
	logic        ack;
	logic [31:0] rdata;
	logic [7:0]  next_port_direction;
	logic [7:0]  next_port_output_data;
	logic        next_slave_mode_enable;
	logic [1:0]  next_cmp_oe;
	logic        next_ack;
	logic [31:0] next_rdata;
	logic        wr_go;
	logic [7:0]  port_read;

	// Registers answer after one cycle; ack drops the cycle after it.
	assign wr_go = wb_cyc_i && wb_stb_i && !ack && wb_we_i && wb_sel_i[0];

	// Direction picks register or pin, independent of pin owner.
	assign port_read = (port_direction & port_output_data) | (~port_direction & pin_i);

	always_comb
	begin
		next_port_direction    = port_direction;
		next_port_output_data  = port_output_data;
		next_slave_mode_enable = slave_mode_enable;
		next_cmp_oe            = cmp_oe;
		next_ack               = wb_cyc_i && wb_stb_i && !ack;
		next_rdata             = rdata;
		if (wb_cyc_i && wb_stb_i && !ack && !wb_we_i)
		begin
			unique case (wb_adr_i)
				PGPM_OFS_DIR:    next_rdata = {24'h00_0000, PGPM_DIR_READ};
				PGPM_OFS_DATA:   next_rdata = {24'h00_0000, port_read};
				PGPM_OFS_SYSCTL: next_rdata = {31'h0000_0000, slave_mode_enable};
				PGPM_OFS_TMRCTL: next_rdata = {30'h0000_0000, cmp_oe};
				default:         next_rdata = PGPM_UNMAPPED;
			endcase
		end
		if (wr_go)
		begin
			unique case (wb_adr_i)
				PGPM_OFS_DIR:    next_port_direction = wb_dat_i[7:0];
				PGPM_OFS_DATA:   next_port_output_data = wb_dat_i[7:0];
				PGPM_OFS_SYSCTL: next_slave_mode_enable = wb_dat_i[PGPM_SME_BIT];
				PGPM_OFS_TMRCTL: next_cmp_oe = {wb_dat_i[PGPM_OEB_BIT], wb_dat_i[PGPM_OEA_BIT]};
				default:         next_rdata = rdata;
			endcase
		end
		// Software standby reinitialises the peripherals but keeps port state.
		if (sw_standby_i)
		begin
			next_slave_mode_enable = 1'b0;
			next_cmp_oe            = 2'b00;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || hw_standby_i)
		begin
			port_direction    <= PGPM_DIR_RST;
			port_output_data  <= PGPM_DATA_RST;
			slave_mode_enable <= 1'b0;
			cmp_oe            <= 2'b00;
			ack               <= 1'b0;
			rdata             <= PGPM_UNMAPPED;
		end
		else
		begin
			port_direction    <= next_port_direction;
			port_output_data  <= next_port_output_data;
			slave_mode_enable <= next_slave_mode_enable;
			cmp_oe            <= next_cmp_oe;
			ack               <= next_ack;
			rdata             <= next_rdata;
		end
	end

	assign wb_dat_o            = rdata;
	assign wb_ack_o            = ack;
	assign slave_mode_enable_o = slave_mode_enable;
	assign periph_reset_o      = sw_standby_i || rst_i || hw_standby_i;

	// ---------------------------------------------------------------
	// Pin multiplexing
	// ---------------------------------------------------------------
	// Pins 5 to 0 only carry the plain port here; their timer functions live elsewhere.
	pgpm_pin_if pa ();
	pgpm_pin_if pb ();

	assign pa.slave_en  = slave_mode_enable;
	assign pa.cmp_oe    = cmp_oe[PGPM_OEA_BIT];
	assign pa.dir       = port_direction[PGPM_PIN_A];
	assign pa.port_out  = port_output_data[PGPM_PIN_A];
	assign pa.cmp_out   = timer_compare_a_out_i;
	assign pa.dpr_out   = dual_port_ram_data_bus_i[PGPM_PIN_A];
	assign pa.dpr_drive = dual_port_ram_drive_i;
	assign pb.slave_en  = slave_mode_enable;
	assign pb.cmp_oe    = cmp_oe[PGPM_OEB_BIT];
	assign pb.dir       = port_direction[PGPM_PIN_B];
	assign pb.port_out  = port_output_data[PGPM_PIN_B];
	assign pb.cmp_out   = timer_compare_b_out_i;
	assign pb.dpr_out   = dual_port_ram_data_bus_i[PGPM_PIN_B];
	assign pb.dpr_drive = dual_port_ram_drive_i;

	pgpm_pin_sel u_sel_a (.p(pa));
	pgpm_pin_sel u_sel_b (.p(pb));

	// Pins 5 to 0 are plain port pins; only 7 and 6 have extra owners here.
	assign pin_o      = {pb.pin_out, pa.pin_out, port_output_data[5:0]};
	assign pin_oe_n_o = {pb.pin_oe_n, pa.pin_oe_n, ~port_direction[5:0]};
	always_comb
	begin
		pin_fn_o[7] = pb.fn;
		pin_fn_o[6] = pa.fn;
	end
	assign dual_port_ram_data_bus_o = pin_i[7:6];

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	dir_read_ones_a: assert property (wb_cyc_i && wb_stb_i && !ack && !wb_we_i
		&& wb_adr_i == PGPM_OFS_DIR |=> wb_ack_o && wb_dat_o[7:0] == 8'hff)
		else $error("direction read not all ones");
	dir_hw_clear_a: assert property (hw_standby_i |=> port_direction == 8'h00)
		else $error("direction not cleared by hardware standby");
	dir_sw_keep_a: assert property (sw_standby_i && !hw_standby_i && !wr_go
		|=> port_direction == $past(port_direction))
		else $error("direction lost in software standby");
	sw_periph_off_a: assert property (sw_standby_i && !hw_standby_i
		|=> !slave_mode_enable && cmp_oe == 2'b00)
		else $error("peripheral not released in standby");
	read_mix_a: assert property (wb_cyc_i && wb_stb_i && !ack && !wb_we_i
		&& wb_adr_i == PGPM_OFS_DATA |=> (wb_dat_o[7:0] & $past(port_direction))
		== ($past(port_output_data) & $past(port_direction)))
		else $error("port read of output bits wrong");
	data_hw_clear_a: assert property (hw_standby_i |=> port_output_data == 8'h00)
		else $error("data not cleared by hardware standby");
	pin7_slave_a: assert property (slave_mode_enable
		|-> pin_oe_n_o[7] == !dual_port_ram_drive_i)
		else $error("pin 7 driver not owned by RAM bus");
	pin6_cmp_a: assert property (!slave_mode_enable && cmp_oe[0]
		|-> !pin_oe_n_o[6] && pin_o[6] == timer_compare_a_out_i)
		else $error("pin 6 compare output wrong");
	pin7_port_a: assert property (!slave_mode_enable && !cmp_oe[1]
		|-> pin_oe_n_o[7] == !port_direction[7])
		else $error("pin 7 port direction wrong");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

	// ---------------------------------------------------------------
	// Bus checks
	// ---------------------------------------------------------------
	dir_write_a: assert property (wr_go && wb_adr_i == PGPM_OFS_DIR
		&& !hw_standby_i |=> port_direction == $past(wb_dat_i[7:0]))
		else $error("direction write lost");
	data_write_a: assert property (wr_go && wb_adr_i == PGPM_OFS_DATA
		&& !hw_standby_i |=> port_output_data == $past(wb_dat_i[7:0]))
		else $error("data write lost");
	sysctl_write_a: assert property (wr_go && wb_adr_i == PGPM_OFS_SYSCTL
		&& !hw_standby_i && !sw_standby_i
		|=> slave_mode_enable == $past(wb_dat_i[PGPM_SME_BIT]))
		else $error("slave mode write lost");
	tmrctl_write_a: assert property (wr_go && wb_adr_i == PGPM_OFS_TMRCTL
		&& !hw_standby_i && !sw_standby_i |=> cmp_oe[1] == $past(wb_dat_i[PGPM_OEB_BIT])
		&& cmp_oe[0] == $past(wb_dat_i[PGPM_OEA_BIT]))
		else $error("compare enable write lost");
	lane_keep_a: assert property (wb_cyc_i && wb_stb_i && wb_we_i
		&& !wb_sel_i[0] && !hw_standby_i |=> port_direction == $past(port_direction)
		&& port_output_data == $past(port_output_data))
		else $error("write without low lane changed a register");
	ack_take_a: assert property (wb_cyc_i && wb_stb_i && !ack && !hw_standby_i |=> wb_ack_o)
		else $error("request not acknowledged");
	ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	dir_read_upper_a: assert property (wb_cyc_i && wb_stb_i && !ack && !wb_we_i
		&& wb_adr_i == PGPM_OFS_DIR && !hw_standby_i |=> wb_dat_o[31:8] == 24'h00_0000)
		else $error("direction read upper bits set");
	sysctl_read_a: assert property (wb_cyc_i && wb_stb_i && !ack && !wb_we_i
		&& wb_adr_i == PGPM_OFS_SYSCTL && !hw_standby_i
		|=> wb_dat_o[31:1] == 31'h0000_0000 && wb_dat_o[0] == $past(slave_mode_enable))
		else $error("slave mode read wrong");
	tmrctl_read_a: assert property (wb_cyc_i && wb_stb_i && !ack && !wb_we_i
		&& wb_adr_i == PGPM_OFS_TMRCTL && !hw_standby_i
		|=> wb_dat_o[31:2] == 30'h0000_0000 && wb_dat_o[1:0] == $past(cmp_oe))
		else $error("compare enable read wrong");
	rdata_hold_a: assert property (!(wb_cyc_i && wb_stb_i && !ack && !wb_we_i)
		&& !hw_standby_i |=> $stable(wb_dat_o))
		else $error("read data changed without a read");

	// ---------------------------------------------------------------
	// Reset and standby checks
	// ---------------------------------------------------------------
	dir_rst_clear_a: assert property ($fell(rst_i)
		|-> port_direction == PGPM_DIR_RST)
		else $error("direction not cleared by reset");
	data_rst_clear_a: assert property ($fell(rst_i)
		|-> port_output_data == PGPM_DATA_RST)
		else $error("data not cleared by reset");
	hw_periph_off_a: assert property (hw_standby_i
		|=> !slave_mode_enable && cmp_oe == 2'b00 && !wb_ack_o)
		else $error("hardware standby left a peripheral or ack on");
	data_sw_keep_a: assert property (sw_standby_i && !hw_standby_i && !wr_go
		|=> port_output_data == $past(port_output_data))
		else $error("data lost in software standby");
	sw_pin_port_a: assert property (sw_standby_i && !hw_standby_i
		|=> pin_oe_n_o == ~port_direction && pin_o == port_output_data)
		else $error("pins not back under port control after standby");
	periph_reset_a: assert property ((sw_standby_i || hw_standby_i) |-> periph_reset_o)
		else $error("peripheral reset missing in standby");

	// ---------------------------------------------------------------
	// Pin checks
	// ---------------------------------------------------------------
	pin6_slave_a: assert property (slave_mode_enable
		|-> pin_oe_n_o[6] == !dual_port_ram_drive_i
		&& pin_o[6] == dual_port_ram_data_bus_i[6])
		else $error("pin 6 not owned by RAM bus");
	pin7_ram_data_a: assert property (slave_mode_enable
		|-> pin_o[7] == dual_port_ram_data_bus_i[7])
		else $error("pin 7 RAM data wrong");
	pin7_cmp_a: assert property (!slave_mode_enable && cmp_oe[1]
		|-> !pin_oe_n_o[7] && pin_o[7] == timer_compare_b_out_i)
		else $error("pin 7 compare output wrong");
	pin6_port_a: assert property (!slave_mode_enable && !cmp_oe[0]
		|-> pin_oe_n_o[6] == !port_direction[6] && pin_o[6] == port_output_data[6])
		else $error("pin 6 port control wrong");
	low_pins_a: assert property (pin_oe_n_o[5:0] == ~port_direction[5:0]
		&& pin_o[5:0] == port_output_data[5:0])
		else $error("plain port pins wrong");
	ram_bus_in_a: assert property (dual_port_ram_data_bus_o == pin_i[7:6])
		else $error("RAM bus input not following pins");
	fn_dontcare_a: assert property (slave_mode_enable
		|-> pin_fn_o[7] == PGPM_FN_DPR && pin_fn_o[6] == PGPM_FN_DPR)
		else $error("slave mode function depends on other bits");
	fn_cmp_a: assert property (!slave_mode_enable && cmp_oe[1]
		|-> pin_fn_o[7] == PGPM_FN_TMR)
		else $error("compare function depends on direction");
	read_pin_a: assert property (wb_cyc_i && wb_stb_i && !ack && !wb_we_i
		&& wb_adr_i == PGPM_OFS_DATA && !hw_standby_i
		|=> (wb_dat_o[7:0] & ~$past(port_direction)) == ($past(pin_i) & ~$past(port_direction)))
		else $error("port read of input bits wrong");
	read_periph_a: assert property (wb_cyc_i && wb_stb_i && !ack && !wb_we_i
		&& wb_adr_i == PGPM_OFS_DATA && !hw_standby_i && (slave_mode_enable || cmp_oe != 2'b00)
		|=> wb_dat_o[7:6] == (($past(port_direction[7:6]) & $past(port_output_data[7:6]))
		| (~$past(port_direction[7:6]) & $past(pin_i[7:6]))))
		else $error("port read of shared pins wrong");

	slave_cv: cover property (slave_mode_enable && dual_port_ram_drive_i);
	cmp_cv: cover property (cmp_oe == 2'b11 && !slave_mode_enable);
	sw_cv: cover property (sw_standby_i && port_direction != 8'h00);
	read_cv: cover property (wb_cyc_i && wb_stb_i && !ack && !wb_we_i
		&& wb_adr_i == PGPM_OFS_DATA);
	port_cv: cover property (!slave_mode_enable && cmp_oe == 2'b00 && port_direction[7]);

endmodule : pgpm_port

// file: inc/pgpm_pin_if.sv
/*
 * Interface carrying one pin's select inputs and resulting drive to the
 * pin selector cell.
 * Assumes one instance per multiplexed pin.
 */
`timescale 1ns/1ns
interface pgpm_pin_if;
	import pgpm_pkg::*;
	logic     slave_en;
	logic     cmp_oe;
	logic     dir;
	logic     port_out;
	logic     cmp_out;
	logic     dpr_out;
	logic     dpr_drive;
	logic     pin_out;
	logic     pin_oe_n;
	pgpm_fn_t fn;

	modport sel (input slave_en, cmp_oe, dir, port_out, cmp_out, dpr_out, dpr_drive,
		output pin_out, pin_oe_n, fn);
	modport top (output slave_en, cmp_oe, dir, port_out, cmp_out, dpr_out, dpr_drive,
		input pin_out, pin_oe_n, fn);
endinterface : pgpm_pin_if

// file: inc/pgpm_pkg.sv
/*
 * Package for the port 4 pin multiplexer: register offsets, reset values,
 * field positions and the pin function encoding.
 * Assumes a 32-bit classic Wishbone register bus with word-aligned registers.
 */
package pgpm_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [3:0] PGPM_OFS_DIR    = 4'h0;
	localparam logic [3:0] PGPM_OFS_DATA   = 4'h4;
	localparam logic [3:0] PGPM_OFS_SYSCTL = 4'h8;
	localparam logic [3:0] PGPM_OFS_TMRCTL = 4'hc;

	// ---------------------------------------------------------------
	// Reset values and fields
	// ---------------------------------------------------------------
	localparam logic [7:0]  PGPM_DIR_RST    = 8'h00;
	localparam logic [7:0]  PGPM_DATA_RST   = 8'h00;
	localparam logic [7:0]  PGPM_DIR_READ   = 8'hff;
	localparam logic [31:0] PGPM_UNMAPPED   = 32'h0000_0000;
	localparam int          PGPM_SME_BIT    = 0;
	localparam int          PGPM_OEA_BIT    = 0;
	localparam int          PGPM_OEB_BIT    = 1;
	localparam int          PGPM_PIN_A      = 6;
	localparam int          PGPM_PIN_B      = 7;

	// ---------------------------------------------------------------
	// Pin function selection
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PGPM_FN_IN   = 2'b00,
		PGPM_FN_OUT  = 2'b01,
		PGPM_FN_TMR  = 2'b10,
		PGPM_FN_DPR  = 2'b11
	} pgpm_fn_t;

endpackage : pgpm_pkg

// file: sim/pgpm_pin_model.sv
/*
 * Outside circuitry on the port pins: resolves each pin level.
 * Assumes an outside source drives every pin the port releases.
 */
`timescale 1ns/1ns
module pgpm_pin_model
(
	input  wire logic [7:0] port_out_i,
	input  wire logic [7:0] port_oe_n_i,
	input  wire logic [7:0] ext_i,
	output logic      [7:0] pin_lvl_o
);
	// The outside source is weak, so a driving port always wins.
	assign pin_lvl_o = (port_oe_n_i & ext_i) | (~port_oe_n_i & port_out_i);
endmodule : pgpm_pin_model

// file: sim/port4_gpio_pin_mux_test.sv
/*
 * Self-checking bench for the port with pins 7 and 6 multiplexed.
 * Assumes the register map of the package and a one-cycle bus answer.
 */
`timescale 1ns/1ns
module port4_gpio_pin_mux_test;
	import pgpm_pkg::*;
	logic           clk_i, rst_i, hws, sws, cyc, stb, we, ta, tb, drv, ack, sme_o, prst, sme;
	logic [3:0]     adr, sel;
	logic [31:0]    wd, rd, dato;
	logic [7:0]     pin_i, pin_o, oe_n, ext, dir, dat;
	logic [7:6]     ram, ram_o;
	logic [1:0]     oe;
	pgpm_fn_t [7:6] fn;
	int             num_errors, compares;

	pgpm_port uut (.clk_i(clk_i), .rst_i(rst_i), .hw_standby_i(hws), .sw_standby_i(sws),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wd), .wb_dat_o(dato), .wb_ack_o(ack), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe_n_o(oe_n), .timer_compare_a_out_i(ta), .timer_compare_b_out_i(tb),
		.dual_port_ram_data_bus_i(ram), .dual_port_ram_drive_i(drv),
		.dual_port_ram_data_bus_o(ram_o), .slave_mode_enable_o(sme_o),
		.periph_reset_o(prst), .pin_fn_o(fn));
	pgpm_pin_model pins (.port_out_i(pin_o), .port_oe_n_i(oe_n), .ext_i(ext), .pin_lvl_o(pin_i));

	// Expected {function, drive enable low, drive value} of a shared pin.
	function automatic logic [3:0] pinf(input logic s, e, d, q, t, r);
		if (s)
			return {PGPM_FN_DPR, ~drv, r};
		if (e)
			return {PGPM_FN_TMR, 1'b0, t};
		return {1'b0, d, ~d, q};
	endfunction : pinf

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask : chk

	// One classic cycle; the request stands until ack is sampled high.
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, sel, wd} <= {2'b11, w, a, s, 24'h0, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = dato;
		{cyc, stb} <= 2'b00;
		chk("ack", 32'(n < 50), 32'h1);
	endtask : wb

	task automatic check_all;
		logic [3:0] p7, p6;
		logic [7:0] eoe, eout, lvl;
		#1;
		p7 = pinf(sme, oe[PGPM_OEB_BIT], dir[7], dat[7], tb, ram[7]);
		p6 = pinf(sme, oe[PGPM_OEA_BIT], dir[6], dat[6], ta, ram[6]);
		eoe = {p7[1], p6[1], ~dir[5:0]};
		eout = {p7[0], p6[0], dat[5:0]};
		lvl = (eoe & ext) | (~eoe & eout);
		chk("pin_oe_n", 32'(oe_n), 32'(eoe));
		chk("pin_out", 32'(pin_o & ~eoe), 32'(eout & ~eoe));
		chk("pin_fn", 32'(fn), 32'({p7[3:2], p6[3:2]}));
		chk("slave", 32'(sme_o), 32'(sme));
		chk("ram_bus_o", 32'(ram_o), 32'(lvl[7:6]));
		wb(1'b0, PGPM_OFS_DATA, 8'h00, 4'hf);
		chk("data", rd, 32'((dir & dat) | (~dir & lvl)));
		wb(1'b0, PGPM_OFS_DIR, 8'h00, 4'hf);
		chk("dir_read", rd, 32'(PGPM_DIR_READ));
	endtask : check_all

	task automatic test_done;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	initial
	begin
		#400000;
		num_errors++;
		test_done;
	end

	initial
	begin
		{rst_i, hws, sws, cyc, stb, we, adr, sel, wd, ta, tb, ram, drv} = '0;
		rst_i = 1'b1;
		ext = 8'($urandom(75));
		{dir, dat, sme, oe, num_errors, compares} = '0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		check_all;
		repeat (12)
		begin
			dir = 8'($urandom);
			dat = 8'($urandom);
			{ext, ta, tb, ram} <= 12'($urandom);
			wb(1'b1, PGPM_OFS_DIR, dir, 4'hf);
			wb(1'b1, PGPM_OFS_DATA, dat, 4'hf);
			check_all;
		end
		// A write without the low byte lane must leave the data alone.
		wb(1'b1, PGPM_OFS_DATA, ~dat, 4'he);
		check_all;
		for (int i = 0; i < 8; i++)
		begin
			sme = i[2];
			oe = i[1:0];
			wb(1'b1, PGPM_OFS_TMRCTL, {6'h0, oe}, 4'hf);
			wb(1'b1, PGPM_OFS_SYSCTL, {7'h0, sme}, 4'hf);
			{drv, ta, tb, ram} <= 5'($urandom);
			check_all;
			wb(1'b0, PGPM_OFS_SYSCTL, 8'h00, 4'hf);
			chk("sysctl", rd, 32'(sme));
			wb(1'b0, PGPM_OFS_TMRCTL, 8'h00, 4'hf);
			chk("tmrctl", rd, 32'(oe));
		end
		wb(1'b1, PGPM_OFS_TMRCTL, 8'h03, 4'hf);
		sws <= 1'b1;
		{sme, oe} = '0;
		@(posedge clk_i);
		chk("periph_reset", 32'(prst), 32'h1);
		check_all;
		sws <= 1'b0;
		check_all;
		hws <= 1'b1;
		repeat (2) @(posedge clk_i);
		hws <= 1'b0;
		{dir, dat} = '0;
		check_all;
		test_done;
	end
endmodule : port4_gpio_pin_mux_test
